// file: rtl/rfc_pkg.sv
// Shared constants and types of the radio frequency configuration bank.
// Assumes an AXI4-Lite master on core_clk with 32-bit data.
package rfc_pkg;

   localparam int ADDR_W = 20;
   localparam int DATA_W = 32;
   localparam int IDX_W  = ADDR_W - 2;

   // Register indices; the byte address is four times the index.
   localparam logic [IDX_W-1:0] IDX_NODE_ADDR   = 18'h0DF05;
   localparam logic [IDX_W-1:0] IDX_CHANNEL     = 18'h0DF06;
   localparam logic [IDX_W-1:0] IDX_IF_CTRL     = 18'h0DF07;
   localparam logic [IDX_W-1:0] IDX_OFFSET_CTRL = 18'h0DF08;
   localparam logic [IDX_W-1:0] IDX_BASE_WORD_A_HIGH   = 18'h0DF09;
   localparam logic [IDX_W-1:0] IDX_BASE_WORD_A_MIDDLE = 18'h0DF0A;
   localparam logic [IDX_W-1:0] IDX_BASE_WORD_A_LOW    = 18'h0DF0B;
   localparam logic [IDX_W-1:0] IDX_MODEM_CFG   = 18'h0DF0C;
   localparam logic [IDX_W-1:0] IDX_SYM_MANT    = 18'h0DF0D;
   localparam logic [IDX_W-1:0] IDX_FILT_CTRL   = 18'h0DF10;
   localparam logic [IDX_W-1:0] IDX_STROBE      = 18'h0DF11;
   localparam logic [1:0]       ADDR_ALIGN      = 2'h0;

   localparam logic [7:0] RST_NODE_ADDR = 8'h00;
   localparam logic [7:0] RST_CHANNEL   = 8'h00;
   localparam logic [4:0] RST_IF_BASE_WORD_A   = 5'h0F;
   localparam logic [7:0] RST_OFFSET    = 8'h00;
   localparam logic [5:0] RST_BASE_WORD_A_HIGH = 6'h1E;
   localparam logic [7:0] RST_BASE_WORD_A_MID  = 8'hC4;
   localparam logic [7:0] RST_BASE_WORD_A_LOW  = 8'hEC;
   localparam logic [1:0] RST_BW_EXP    = 2'h2;
   localparam logic [1:0] RST_BW_MANT   = 2'h0;
   localparam logic [3:0] RST_SYM_EXP   = 4'hC;
   localparam logic [7:0] RST_SYM_MANT  = 8'h22;
   localparam logic [1:0] BASE_WORD_A_TOP_BITS = 2'h1;
   localparam logic       HIDDEN_ONE    = 1'h1;
   localparam logic [7:0] BCAST_ZERO    = 8'h00;
   localparam logic [7:0] BCAST_ONES    = 8'hFF;
   localparam int         STROBE_BIT    = 0;
   // Offset steps are 4 base-word steps, IF steps are 64.
   localparam int         OFFSET_SHIFT  = 2;
   localparam int         IF_SHIFT      = 6;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      FILT_NONE    = 2'h0,
      FILT_EXACT   = 2'h1,
      FILT_ZERO_BC = 2'h2,
      FILT_BOTH_BC = 2'h3
   } rfc_filt_mode_t;

   typedef enum logic [1:0] {
      WR_IDLE = 2'b01,
      WR_RESP = 2'b10
   } rfc_wr_state_t;

   typedef struct packed {
      logic [1:0] bw_exp;
      logic [1:0] bw_mant;
      logic [3:0] sym_exp;
   } rfc_modem_cfg_t;

   localparam rfc_modem_cfg_t RST_MODEM = '{
      bw_exp: RST_BW_EXP, bw_mant: RST_BW_MANT, sym_exp: RST_SYM_EXP};

   typedef struct packed {
      logic              awvalid;
      logic [ADDR_W-1:0] awaddr;
      logic [2:0]        awprot;
      logic              wvalid;
      logic [DATA_W-1:0] wdata;
      logic [3:0]        wstrb;
      logic              bready;
      logic              arvalid;
      logic [ADDR_W-1:0] araddr;
      logic [2:0]        arprot;
      logic              rready;
   } rfc_axi_req_t;

   typedef struct packed {
      logic              awready;
      logic              wready;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              arready;
      logic              rvalid;
      logic [DATA_W-1:0] rdata;
      logic [1:0]        rresp;
   } rfc_axi_rsp_t;

   typedef struct packed {
      logic [7:0]        node_addr;
      logic [7:0]        channel;
      logic [4:0]        if_base_word_a;
      logic [7:0]        offset;
      logic [5:0]        base_word_a_high;
      logic [7:0]        base_word_a_mid;
      logic [7:0]        base_word_a_low;
      rfc_modem_cfg_t    modem;
      logic [7:0]        sym_mant;
      rfc_filt_mode_t    filt_mode;
      rfc_wr_state_t     wr_state;
      logic              aw_have;
      logic [ADDR_W-1:0] aw_addr;
      logic              w_have;
      logic [DATA_W-1:0] w_data;
      logic [3:0]        w_strb;
      logic [1:0]        bresp;
      logic              rvalid;
      logic [DATA_W-1:0] rdata;
      logic [1:0]        rresp;
      logic              accept;
      logic              accept_valid;
      logic [23:0]       synth_word;
   } rfc_state_t;

   localparam rfc_state_t RST_STATE = '{
      node_addr: RST_NODE_ADDR, channel: RST_CHANNEL, if_base_word_a: RST_IF_BASE_WORD_A,
      offset: RST_OFFSET, base_word_a_high: RST_BASE_WORD_A_HIGH, base_word_a_mid: RST_BASE_WORD_A_MID,
      base_word_a_low: RST_BASE_WORD_A_LOW, modem: RST_MODEM, sym_mant: RST_SYM_MANT,
      filt_mode: FILT_NONE, wr_state: WR_IDLE, aw_have: 1'h0,
      aw_addr: '0, w_have: 1'h0, w_data: '0, w_strb: 4'h0,
      bresp: RESP_OKAY, rvalid: 1'h0, rdata: '0, rresp: RESP_OKAY,
      accept: 1'h0, accept_valid: 1'h0, synth_word: 24'h000000};

endpackage

// file: rtl/rfc_regs.sv
// Frequency and modem configuration registers with address filtering.
// Assumes an AXI4-Lite master, and that the estimate, correction and
// packet inputs come from logic on core_clk.
//
// What this block does
// - Hold an 8-bit node address, reset zero, compared against packets.
// - Channel number unsigned, times channel spacing, added to base word.
// - Five-bit IF field, reset 01111, subtracted from base in receive only.
// - Offset register is two's complement, added to base, reset zero.
// - Correction strobe or automatic correction adds estimate into offset.
// - Top two bits of the frequency word are read-only and read 01.
// - Base word assembled from high, middle, low bytes; resets 1E, C4, EC.
// - Bandwidth exponent resets 10, mantissa resets 00; set decimation.
// - Symbol-rate exponent is bits 3 to 0, reset 1100.
// - Symbol-rate mantissa gains a hidden leading one above eight bits.
// - Filter mode: none, exact, zero broadcast, zero and ones broadcast.
//
// Decided for this implementation: register access over AXI4-Lite.
module rfc_regs (
   input  wire logic                 core_clk,
   input  wire logic                 rst,
   input  wire rfc_pkg::rfc_axi_req_t axi_req,
   output rfc_pkg::rfc_axi_rsp_t     axi_rsp,
   input  wire logic                 pkt_addr_valid,
   input  wire logic [7:0]           pkt_addr,
   input  wire logic                 rx_active,
   input  wire logic                 afc_run,
   input  wire logic [7:0]           base_word_a_estimate_value,
   input  wire logic [15:0]          channel_index_spacing,
   output logic                      addr_accept,
   output logic                      addr_accept_valid,
   output logic [7:0]                node_address,
   output logic [7:0]                channel_index,
   output logic [4:0]                if_base_word_a_setting,
   output logic [7:0]                base_word_a_offset_value,
   output logic [23:0]               base_word_a,
   output logic [23:0]               synth_base_word_a_word,
   output logic [1:0]                bandwidth_exponent,
   output logic [1:0]                bandwidth_mantissa,
   output logic [3:0]                symrate_exponent,
   output logic [8:0]                symrate_mantissa,
   output logic [1:0]                addr_filter_mode
);

   rfc_pkg::rfc_state_t cur;
   rfc_pkg::rfc_state_t nxt;

   logic                         aw_fire;
   logic                         w_fire;
   logic                         ar_fire;
   logic                         wr_go;
   logic [rfc_pkg::ADDR_W-1:0]   wr_addr;
   logic [rfc_pkg::DATA_W-1:0]   wr_data;
   logic [3:0]                   wr_strb;
   logic                         wr_en;
   logic [rfc_pkg::IDX_W-1:0]    wr_idx;
   logic                         strobe_hit;
   logic                         acc_go;

   function automatic logic [rfc_pkg::IDX_W-1:0] idx_of(
      input logic [rfc_pkg::ADDR_W-1:0] a);
      idx_of = a[rfc_pkg::ADDR_W-1:2];
   endfunction

   function automatic logic mapped(input logic [rfc_pkg::ADDR_W-1:0] a);
      logic [rfc_pkg::IDX_W-1:0] i;
      i = idx_of(a);
      mapped = (a[1:0] == rfc_pkg::ADDR_ALIGN) &&
               (i == rfc_pkg::IDX_NODE_ADDR   || i == rfc_pkg::IDX_CHANNEL ||
                i == rfc_pkg::IDX_IF_CTRL     ||
                i == rfc_pkg::IDX_OFFSET_CTRL ||
                i == rfc_pkg::IDX_BASE_WORD_A_HIGH   ||
                i == rfc_pkg::IDX_BASE_WORD_A_MIDDLE ||
                i == rfc_pkg::IDX_BASE_WORD_A_LOW    ||
                i == rfc_pkg::IDX_MODEM_CFG   ||
                i == rfc_pkg::IDX_SYM_MANT    ||
                i == rfc_pkg::IDX_FILT_CTRL   || i == rfc_pkg::IDX_STROBE);
   endfunction

   function automatic logic [7:0] read_byte(input rfc_pkg::rfc_state_t s,
                                            input logic [rfc_pkg::IDX_W-1:0] i);
      read_byte = 8'h00;
      if (i == rfc_pkg::IDX_NODE_ADDR) begin
         read_byte = s.node_addr;
      end else if (i == rfc_pkg::IDX_CHANNEL) begin
         read_byte = s.channel;
      end else if (i == rfc_pkg::IDX_IF_CTRL) begin
         read_byte = {3'h0, s.if_base_word_a};
      end else if (i == rfc_pkg::IDX_OFFSET_CTRL) begin
         read_byte = s.offset;
      end else if (i == rfc_pkg::IDX_BASE_WORD_A_HIGH) begin
         read_byte = {rfc_pkg::BASE_WORD_A_TOP_BITS, s.base_word_a_high};
      end else if (i == rfc_pkg::IDX_BASE_WORD_A_MIDDLE) begin
         read_byte = s.base_word_a_mid;
      end else if (i == rfc_pkg::IDX_BASE_WORD_A_LOW) begin
         read_byte = s.base_word_a_low;
      end else if (i == rfc_pkg::IDX_MODEM_CFG) begin
         read_byte = s.modem;
      end else if (i == rfc_pkg::IDX_SYM_MANT) begin
         read_byte = s.sym_mant;
      end else if (i == rfc_pkg::IDX_FILT_CTRL) begin
         read_byte = {6'h00, s.filt_mode};
      end
   endfunction

   function automatic logic filter_ok(input rfc_pkg::rfc_filt_mode_t m,
                                      input logic [7:0] node,
                                      input logic [7:0] a);
      logic zero_bc;
      logic ones_bc;
      zero_bc = (a == rfc_pkg::BCAST_ZERO);
      ones_bc = (a == rfc_pkg::BCAST_ONES);
      unique case (m)
         rfc_pkg::FILT_NONE:    filter_ok = 1'b1;
         rfc_pkg::FILT_EXACT:   filter_ok = (a == node);
         rfc_pkg::FILT_ZERO_BC: filter_ok = (a == node) || zero_bc;
         rfc_pkg::FILT_BOTH_BC: filter_ok = (a == node) || zero_bc || ones_bc;
      endcase
   endfunction

   // Base plus channel times spacing, plus offset, minus IF in receive.
   function automatic logic [23:0] synth_of(input rfc_pkg::rfc_state_t s,
                                            input logic [15:0] spacing,
                                            input logic rx);
      logic [23:0] base;
      logic [23:0] channel_index_term;
      logic [23:0] off_term;
      logic [23:0] if_term;
      base      = {rfc_pkg::BASE_WORD_A_TOP_BITS, s.base_word_a_high, s.base_word_a_mid,
                   s.base_word_a_low};
      channel_index_term = 24'(s.channel) * 24'(spacing);
      // Sign-extended offset scaled to base steps.
      off_term  = 24'({{16{s.offset[7]}}, s.offset} << rfc_pkg::OFFSET_SHIFT);
      if_term   = rx ? 24'({19'h0, s.if_base_word_a} << rfc_pkg::IF_SHIFT) : 24'h0;
      synth_of  = 24'(base + channel_index_term + off_term - if_term);
   endfunction

   assign axi_rsp.awready = (cur.wr_state == rfc_pkg::WR_IDLE) && !cur.aw_have;
   assign axi_rsp.wready  = (cur.wr_state == rfc_pkg::WR_IDLE) && !cur.w_have;
   assign axi_rsp.bvalid  = (cur.wr_state == rfc_pkg::WR_RESP);
   assign axi_rsp.bresp   = cur.bresp;
   assign axi_rsp.arready = !cur.rvalid;
   assign axi_rsp.rvalid  = cur.rvalid;
   assign axi_rsp.rdata   = cur.rdata;
   assign axi_rsp.rresp   = cur.rresp;

   assign aw_fire = axi_req.awvalid && axi_rsp.awready;
   assign w_fire  = axi_req.wvalid && axi_rsp.wready;
   assign ar_fire = axi_req.arvalid && axi_rsp.arready;
   assign wr_addr = cur.aw_have ? cur.aw_addr : axi_req.awaddr;
   assign wr_data = cur.w_have ? cur.w_data : axi_req.wdata;
   assign wr_strb = cur.w_have ? cur.w_strb : axi_req.wstrb;
   assign wr_go   = (aw_fire || cur.aw_have) && (w_fire || cur.w_have);
   // Only byte lane 0 carries register data; other lanes are ignored.
   assign wr_en   = wr_go && wr_strb[0] && mapped(wr_addr);
   assign wr_idx  = idx_of(wr_addr);
   assign strobe_hit = wr_en && (wr_idx == rfc_pkg::IDX_STROBE) &&
                       wr_data[rfc_pkg::STROBE_BIT];
   // Software strobe or automatic run both accumulate.
   assign acc_go  = strobe_hit || afc_run;

   always_comb begin
      nxt = cur;
      if (aw_fire) begin
         nxt.aw_have = 1'b1;
         nxt.aw_addr = axi_req.awaddr;
      end
      if (w_fire) begin
         nxt.w_have = 1'b1;
         nxt.w_data = axi_req.wdata;
         nxt.w_strb = axi_req.wstrb;
      end
      if (wr_go) begin
         nxt.aw_have  = 1'b0;
         nxt.w_have   = 1'b0;
         nxt.wr_state = rfc_pkg::WR_RESP;
         nxt.bresp    = mapped(wr_addr) ? rfc_pkg::RESP_OKAY
                                        : rfc_pkg::RESP_SLVERR;
      end else if (cur.wr_state == rfc_pkg::WR_RESP && axi_req.bready) begin
         nxt.wr_state = rfc_pkg::WR_IDLE;
      end
      // Writable fields store the written value.
      if (wr_en) begin
         if (wr_idx == rfc_pkg::IDX_NODE_ADDR) begin
            nxt.node_addr = wr_data[7:0];
         end
         if (wr_idx == rfc_pkg::IDX_CHANNEL) begin
            nxt.channel = wr_data[7:0];
         end
         if (wr_idx == rfc_pkg::IDX_IF_CTRL) begin
            nxt.if_base_word_a = wr_data[4:0];
         end
         if (wr_idx == rfc_pkg::IDX_OFFSET_CTRL) begin
            nxt.offset = wr_data[7:0];
         end
         if (wr_idx == rfc_pkg::IDX_BASE_WORD_A_HIGH) begin
            nxt.base_word_a_high = wr_data[5:0];
         end
         if (wr_idx == rfc_pkg::IDX_BASE_WORD_A_MIDDLE) begin
            nxt.base_word_a_mid = wr_data[7:0];
         end
         if (wr_idx == rfc_pkg::IDX_BASE_WORD_A_LOW) begin
            nxt.base_word_a_low = wr_data[7:0];
         end
         if (wr_idx == rfc_pkg::IDX_MODEM_CFG) begin
            nxt.modem = rfc_pkg::rfc_modem_cfg_t'(wr_data[7:0]);
         end
         if (wr_idx == rfc_pkg::IDX_SYM_MANT) begin
            nxt.sym_mant = wr_data[7:0];
         end
         if (wr_idx == rfc_pkg::IDX_FILT_CTRL) begin
            nxt.filt_mode = rfc_pkg::rfc_filt_mode_t'(wr_data[1:0]);
         end
      end
      // Accumulate on top of any same-cycle offset write.
      // A write and a correction in one cycle both take effect, so
      // neither a software value nor an estimate is silently dropped.
      if (acc_go) begin
         nxt.offset = 8'(nxt.offset + base_word_a_estimate_value);
      end
      if (ar_fire) begin
         nxt.rvalid = 1'b1;
         nxt.rdata  = {24'h000000, read_byte(cur, idx_of(axi_req.araddr))};
         nxt.rresp  = mapped(axi_req.araddr) ? rfc_pkg::RESP_OKAY
                                             : rfc_pkg::RESP_SLVERR;
      end else if (cur.rvalid && axi_req.rready) begin
         nxt.rvalid = 1'b0;
      end
      // Filter decision one cycle after each packet address.
      nxt.accept_valid = pkt_addr_valid;
      nxt.accept       = pkt_addr_valid &&
                         filter_ok(cur.filt_mode, cur.node_addr, pkt_addr);
      nxt.synth_word   = synth_of(cur, channel_index_spacing, rx_active);
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cur <= rfc_pkg::RST_STATE;
      end else begin
         cur <= nxt;
      end
   end

   assign addr_accept        = cur.accept;
   assign addr_accept_valid  = cur.accept_valid;
   assign node_address       = cur.node_addr;
   assign channel_index      = cur.channel;
   assign if_base_word_a_setting    = cur.if_base_word_a;
   assign base_word_a_offset_value  = cur.offset;
   // Base word assembled from the three byte registers.
   assign base_word_a        = {rfc_pkg::BASE_WORD_A_TOP_BITS, cur.base_word_a_high,
                                cur.base_word_a_mid, cur.base_word_a_low};
   assign synth_base_word_a_word    = cur.synth_word;
   assign bandwidth_exponent = cur.modem.bw_exp;
   assign bandwidth_mantissa = cur.modem.bw_mant;
   assign symrate_exponent   = cur.modem.sym_exp;
   assign symrate_mantissa   = {rfc_pkg::HIDDEN_ONE, cur.sym_mant};
   assign addr_filter_mode   = cur.filt_mode;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   sequence wr_done_s;
      wr_go;
   endsequence

   sequence resp_held_s;
      axi_rsp.bvalid && !axi_req.bready;
   endsequence

   write_resp_a: assert property (wr_done_s |=> axi_rsp.bvalid ##0
      (axi_rsp.bresp == rfc_pkg::RESP_OKAY) == $past(mapped(wr_addr)))
      else $error("write response missing or wrong");

   resp_hold_a: assert property (resp_held_s |=> axi_rsp.bvalid)
      else $error("write response dropped early");

   exact_reject_a: assert property (pkt_addr_valid &&
      cur.filt_mode == rfc_pkg::FILT_EXACT && pkt_addr != cur.node_addr
      |=> addr_accept_valid && !addr_accept)
      else $error("exact filter accepted a foreign address");

   ones_bcast_a: assert property (pkt_addr_valid &&
      cur.filt_mode == rfc_pkg::FILT_BOTH_BC &&
      pkt_addr == rfc_pkg::BCAST_ONES |=> addr_accept)
      else $error("all-ones broadcast not accepted");

   zero_only_a: assert property (pkt_addr_valid &&
      cur.filt_mode == rfc_pkg::FILT_ZERO_BC && pkt_addr != cur.node_addr &&
      pkt_addr != rfc_pkg::BCAST_ZERO |=> !addr_accept)
      else $error("zero broadcast mode accepted a foreign address");

   offset_acc_a: assert property (afc_run && !wr_en |=>
      base_word_a_offset_value == 8'($past(base_word_a_offset_value) +
                              $past(base_word_a_estimate_value)))
      else $error("offset did not accumulate the estimate");

   top_bits_a: assert property (base_word_a[23:22] ==
      rfc_pkg::BASE_WORD_A_TOP_BITS)
      else $error("frequency word top bits not 01");

   if_stable_a: assert property ($changed(if_base_word_a_setting) |->
      $past(wr_en) && $past(wr_idx) == rfc_pkg::IDX_IF_CTRL)
      else $error("IF field changed without a write");

   // The word is built from the previous cycle's fields, so the check
   // looks back one cycle at every operand.
   synth_tx_a: assert property (!rx_active |=>
      synth_base_word_a_word == 24'($past(base_word_a) +
      24'($past(channel_index)) * 24'($past(channel_index_spacing)) +
      24'({{16{$past(base_word_a_offset_value[7])}}, $past(base_word_a_offset_value)}
      << rfc_pkg::OFFSET_SHIFT)))
      else $error("synthesizer word mismatch in transmit");

   bw_stable_a: assert property ($changed({bandwidth_exponent,
      bandwidth_mantissa, symrate_exponent}) |->
      $past(wr_idx) == rfc_pkg::IDX_MODEM_CFG && $past(wr_en))
      else $error("modem fields changed without a write");

   hidden_one_a: assert property (symrate_mantissa[8] ==
      rfc_pkg::HIDDEN_ONE)
      else $error("symbol-rate hidden one missing");

endmodule

// file: verif/rfc_testbench.sv
// Self-checking bench for the frequency configuration register bank.
// Assumes the bank alone on core_clk; this bench is its AXI4-Lite master.
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic                  core_clk;
   logic                  rst;
   rfc_pkg::rfc_axi_req_t req;
   rfc_pkg::rfc_axi_rsp_t rsp;
   logic                  pkt_addr_valid;
   logic [7:0]            pkt_addr;
   logic                  rx_active;
   logic                  afc_run;
   logic [7:0]            est;
   logic [15:0]           spacing;
   logic                  acc;
   logic                  acc_valid;
   logic [7:0]            node_o;
   logic [7:0]            channel_index_o;
   logic [4:0]            if_o;
   logic [7:0]            off_o;
   logic [23:0]           base_o;
   logic [23:0]           synth_o;
   logic [1:0]            bwe_o;
   logic [1:0]            bwm_o;
   logic [3:0]            sye_o;
   logic [8:0]            sym_o;
   logic [1:0]            mode_o;
   logic [33:0]           rd_q[$];
   logic                  acc_q[$];
   logic [7:0]            wv[8];
   logic [1:0]            resp;
   logic [31:0]           d;
   logic [7:0]            pk[4];
   logic [23:0]           e24;
   int                    err_count;
   int                    compares;
   int                    k;
   int                    m;
   logic [17:0] ridx[11] = '{18'h0DF05, 18'h0DF06, 18'h0DF07, 18'h0DF08,
      18'h0DF09, 18'h0DF0A, 18'h0DF0B, 18'h0DF0C, 18'h0DF0D, 18'h0DF10,
      18'h0DF11};
   logic [7:0]  rval[11] = '{8'h00, 8'h00, 8'h0F, 8'h00, 8'h5E, 8'hC4,
      8'hEC, 8'h8C, 8'h22, 8'h00, 8'h00};

   rfc_regs i_dut (.core_clk(core_clk), .rst(rst), .axi_req(req),
      .axi_rsp(rsp), .pkt_addr_valid(pkt_addr_valid), .pkt_addr(pkt_addr),
      .rx_active(rx_active), .afc_run(afc_run), .base_word_a_estimate_value(est),
      .channel_index_spacing(spacing), .addr_accept(acc),
      .addr_accept_valid(acc_valid), .node_address(node_o),
      .channel_index(channel_index_o), .if_base_word_a_setting(if_o),
      .base_word_a_offset_value(off_o), .base_word_a(base_o),
      .synth_base_word_a_word(synth_o), .bandwidth_exponent(bwe_o),
      .bandwidth_mantissa(bwm_o), .symrate_exponent(sye_o),
      .symrate_mantissa(sym_o), .addr_filter_mode(mode_o));

   always #20 core_clk = ~core_clk;

   task automatic check(input logic [33:0] got, exp, input string what);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what,
            got, exp);
      end
   endtask

   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic timeout;
      err_count++;
      $display("CHECK FAILED at %0t: bus wait ran out", $time);
      complete_run();
   endtask

   function automatic logic [19:0] ba(input logic [17:0] i);
      return {i, 2'h0};
   endfunction

   // The ready of each channel is looked at on the falling edge, so the
   // handshake seen is the one that the next rising edge completes.
   // The response is left waiting one cycle so that a held response is
   // exercised on every write.
   task automatic axi_write(input logic [19:0] a, input logic [31:0] v);
      logic aw_t, w_t, b_t, v_t;
      int n;
      req.awvalid <= 1'b1;
      req.awaddr <= a;
      req.wvalid <= 1'b1;
      req.wdata <= v;
      req.wstrb <= 4'hF;
      req.bready <= 1'b0;
      for (n = 0; n < 50; n++) begin
         @(negedge core_clk);
         aw_t = req.awvalid && rsp.awready;
         w_t = req.wvalid && rsp.wready;
         v_t = rsp.bvalid;
         b_t = v_t && req.bready;
         resp = rsp.bresp;
         @(posedge core_clk);
         if (aw_t) req.awvalid <= 1'b0;
         if (w_t) req.wvalid <= 1'b0;
         if (b_t) break;
         if (v_t) req.bready <= 1'b1;
      end
      if (n == 50) timeout();
   endtask

   task automatic rd_exp(input logic [19:0] a, input logic [7:0] e,
                         input logic [1:0] r);
      logic ar_t, r_t;
      int n;
      rd_q.push_back({r, 24'h0, e});
      req.arvalid <= 1'b1;
      req.araddr <= a;
      for (n = 0; n < 50; n++) begin
         @(negedge core_clk);
         ar_t = req.arvalid && rsp.arready;
         r_t = rsp.rvalid;
         @(posedge core_clk);
         if (ar_t) req.arvalid <= 1'b0;
         if (r_t) break;
      end
      if (n == 50) timeout();
   endtask

   always @(negedge core_clk) begin
      if (rsp.rvalid === 1'b1) begin
         check({rsp.rresp, rsp.rdata}, rd_q.pop_front(), "read");
      end
      if (acc_valid === 1'b1) begin
         check({33'h0, acc}, {33'h0, acc_q.pop_front()}, "filter");
      end
   end

   initial begin
      core_clk = 1'b0;
      rst = 1'b1;
      req = '0;
      req.bready = 1'b1;
      req.rready = 1'b1;
      {pkt_addr_valid, pkt_addr, rx_active, afc_run, est, spacing} = '0;
      err_count = 0;
      compares = 0;
      void'($urandom(32'h8009));
      repeat (2) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      for (k = 0; k < 11; k++) rd_exp(ba(ridx[k]), rval[k], 2'h0);
      $display("test reset values done");
      for (k = 0; k < 8; k++) begin
         d = $urandom;
         wv[k] = d[7:0];
         axi_write(ba(ridx[k]), d);
         check({32'h0, resp}, 34'h0, "write resp");
      end
      rd_exp(ba(ridx[2]), {3'h0, wv[2][4:0]}, 2'h0);
      rd_exp(ba(ridx[4]), {2'h1, wv[4][5:0]}, 2'h0);
      for (k = 0; k < 8; k++) begin
         if (k != 2 && k != 4) rd_exp(ba(ridx[k]), wv[k], 2'h0);
      end
      check({26'h0, bwe_o, bwm_o, sye_o}, {26'h0, wv[7]}, "modem");
      check({13'h0, node_o, channel_index_o, if_o},
         {13'h0, wv[0], wv[1], wv[2][4:0]}, "fields");
      check({25'h0, sym_o}, {25'h0, 9'h122}, "mantissa");
      check({10'h0, base_o}, {10'h0, 2'h1, wv[4][5:0], wv[5], wv[6]},
         "base");
      for (m = 0; m < 2; m++) begin
         spacing <= 16'($urandom);
         rx_active <= m[0];
         repeat (3) @(posedge core_clk);
         @(negedge core_clk);
         e24 = {2'h1, wv[4][5:0], wv[5], wv[6]} + wv[1] * spacing
            + {{14{wv[3][7]}}, wv[3], 2'h0}
            - (m[0] ? {13'h0, wv[2][4:0], 6'h0} : 24'h0);
         check({10'h0, synth_o}, {10'h0, e24}, "synth word");
         @(posedge core_clk);
      end
      $display("test write readback done");
      rd_exp(ba(18'h0DF0F), 8'h00, 2'h2);
      rd_exp(ba(ridx[0]) + 20'h1, wv[0], 2'h2);
      axi_write(ba(18'h0DF0E), 32'h5A);
      check({32'h0, resp}, 34'h2, "unmapped write");
      $display("test refusals done");
      axi_write(ba(ridx[3]), 32'h7C);
      est <= 8'hF3;
      axi_write(ba(ridx[10]), 32'h1);
      rd_exp(ba(ridx[3]), 8'h6F, 2'h0);
      afc_run <= 1'b1;
      repeat (3) @(posedge core_clk);
      afc_run <= 1'b0;
      @(negedge core_clk);
      check({26'h0, off_o}, {26'h0, 8'h48}, "accumulated offset");
      @(posedge core_clk);
      $display("test correction done");
      d = $urandom;
      if (d[7:0] == 8'h00 || d[7:0] == 8'hFF) d[7:0] = 8'h5A;
      pk = '{d[7:0], d[7:0] ^ 8'h01, 8'h00, 8'hFF};
      axi_write(ba(ridx[0]), d);
      for (m = 0; m < 4; m++) begin
         axi_write(ba(ridx[9]), m);
         check({32'h0, mode_o}, 34'(m), "filter mode");
         for (k = 0; k < 4; k++) begin
            @(posedge core_clk);
            pkt_addr_valid <= 1'b1;
            pkt_addr <= pk[k];
            acc_q.push_back(m == 0 || pk[k] == d[7:0]
               || (m >= 2 && pk[k] == 8'h00)
               || (m == 3 && pk[k] == 8'hFF));
         end
         @(posedge core_clk);
         pkt_addr_valid <= 1'b0;
         repeat (2) @(posedge core_clk);
      end
      $display("test address filter done");
      check(34'(rd_q.size() + acc_q.size()), 34'h0, "notes left");
      complete_run();
   end
endmodule
